// [eed_pkg.sv]
/*
 * Shared constants and types for the serial EEPROM instruction decoder:
 * op-codes, sub-codes, field widths, clock counts and command kinds.
 * Assumes nothing of its surroundings; imported by every design file.
 */
`default_nettype none
package eed_pkg;
   // Op-codes shifted in after the start bit
   localparam logic [1:0] OPC_READ = 2'h2;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_ERASE = 2'h3;
   localparam logic [1:0] OPC_SPECIAL = 2'h0;
   // Sub-codes in the two leading address bits under OPC_SPECIAL
   localparam logic [1:0] ENABLE_WRITES_CMD = 2'h3;
   localparam logic [1:0] DISABLE_WRITES_CMD = 2'h0;
   localparam logic [1:0] ERASE_ALL_SUB = 2'h2;
   localparam logic [1:0] FILL_ALL_SUB = 2'h1;
   // Field widths and clock counts
   localparam int ADDR_MAX_W = 11;
   localparam int DATA_MAX_W = 16;
   localparam logic [4:0] BYTE_W = 5'h08;
   localparam logic [4:0] WORD_W = 5'h10;
   localparam logic [4:0] HDR_CLKS = 5'h03;
   localparam logic [3:0] ABASE_1K = 4'h6;
   localparam logic [3:0] ABASE_4K = 4'h8;
   localparam logic [3:0] ABASE_16K = 4'hA;
   localparam logic [4:0] CNT_MAX = 5'h1F;
   // Values after reset
   localparam logic WEN_RST = 1'b0;
   localparam logic DOUT_RST = 1'b0;
   // Command kinds handed to the array sequencer
   typedef enum logic [1:0] {
      write_one_cmd = 2'h0,
      erase_one_cmd = 2'h1,
      erase_everything_cmd = 2'h2,
      fill_everything_cmd = 2'h3
   } eed_cmd_t;
   localparam int CMD_W = 2 + ADDR_MAX_W + DATA_MAX_W;
   // Decoder states, one-hot
   typedef enum logic [7:0] {
      st_idle = 8'h01,
      st_hunt = 8'h02,
      st_opc = 8'h04,
      st_addr = 8'h08,
      st_data = 8'h10,
      st_read = 8'h20,
      st_tail = 8'h40,
      st_status = 8'h80
   } eed_state_t;
endpackage
`default_nettype wire

// [eed_sync.sv]
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk_in; only stage two is read.
 */
`default_nettype none
module eed_sync
   import eed_pkg::*;
#(
   parameter int WIDTH = 3
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // Both stages in one struct
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } eed_sync_t;
   eed_sync_t sync_q;
   eed_sync_t sync_d;

   // Shift through two stages
   always_comb
   begin
      sync_d.s1 = async_in;
      sync_d.s2 = sync_q.s1;
   end

   // Register the stages
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         sync_q <= '0;
      end
      else
      begin
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q.s2;
endmodule
`default_nettype wire

// [eed_buf2.sv]
/*
 * Two-entry buffer with registered outputs (output stage plus spare).
 * Assumes the consumer may hold out_ready_in low indefinitely.
 */
`default_nettype none
module eed_buf2
   import eed_pkg::*;
#(
   parameter int WIDTH = CMD_W
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   // Head entry drives the outputs, spare catches a stalled push
   typedef struct packed {
      logic hv;
      logic [WIDTH-1:0] hd;
      logic sv;
      logic [WIDTH-1:0] sd;
   } eed_buf_t;
   eed_buf_t b_q;
   eed_buf_t b_d;
   logic push;
   logic pop;

   // Move spare to head on pop, park new words behind
   always_comb
   begin
      b_d = b_q;
      push = in_valid_in && !b_q.sv;
      pop = b_q.hv && out_ready_in;
      if (pop)
      begin
         b_d.hv = b_q.sv;
         b_d.hd = b_q.sd;
         b_d.sv = 1'b0;
      end
      if (push)
      begin
         // Land in head if it is free after this cycle
         if (!b_d.hv)
         begin
            b_d.hv = 1'b1;
            b_d.hd = in_data_in;
         end
         else
         begin
            b_d.sv = 1'b1;
            b_d.sd = in_data_in;
         end
      end
   end

   // Register the entries
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         b_q <= '0;
      end
      else
      begin
         b_q <= b_d;
      end
   end

   // Full means spare taken; ready is a flop, never a loop
   assign in_ready_out = !b_q.sv;
   assign out_valid_out = b_q.hv;
   assign out_data_out = b_q.hd;
endmodule
`default_nettype wire

// [eed_decoder.sv]
/*
 * Serial EEPROM instruction decoder: samples select, serial clock, data
 * and width-select pins, decodes the seven instructions, checks the clock
 * count, streams read data and hands write/erase commands to the array.
 * Assumes an array sequencer on clk_in that answers read requests within
 * a few cycles and reports its self-timed cycle on array_busy_in.
 */
// Summary of operation
// - Seven instructions: read, write, enable, disable, erase, erases, fills
// - First sampled 1 after select is start
// - Two op-code bits then address, MSB first
// - 10 read, 01 write, 11 erase
// - Op 00: address top bits pick sub-instruction
// - Width pin 0 byte, 1 word
// - 1-Kbit: address 6 word, 7 byte
// - 2/4-Kbit: address 8 word, 9 byte
// - 8/16-Kbit: address 10 word, 11 byte
// - 2-Kbit ignores top address bit
// - 8-Kbit ignores top address bit
// - 1-Kbit clock counts 18/25, 10/9
// - 2/4-Kbit clock counts 20/27, 12/11
// - 8/16-Kbit clock counts 22/29, 14/13
// - Write and fill shift data MSB first
// - Fully static: no minimum serial clock rate; edges sampled on clk_in
// - Read: dummy 0, MSB first, auto-increment
// - Wrong clock count aborts modifying instructions
// - Writes disabled at reset until enabled
// - Busy shows 0, ready 1; input ignored
`default_nettype none
module eed_decoder
   import eed_pkg::*;
#(
   parameter int DENSITY_KBIT = 16
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic sel_in,
   input wire logic sclk_in,
   input wire logic din_in,
   input wire logic org_in,
   output logic dout_out,
   output logic dout_oe_out,
   output logic wen_out,
   output logic rd_req_out,
   output logic [ADDR_MAX_W-1:0] rd_addr_out,
   input wire logic rd_ack_in,
   input wire logic [DATA_MAX_W-1:0] rd_data_in,
   input wire logic array_busy_in,
   output logic cmd_valid_out,
   output logic [1:0] cmd_kind_out,
   output logic [ADDR_MAX_W-1:0] cmd_addr_out,
   output logic [DATA_MAX_W-1:0] cmd_data_out,
   input wire logic cmd_ready_in
);
   // Address base width and ignored top bit per density
   localparam logic [3:0] ABASE = (DENSITY_KBIT == 1) ? ABASE_1K :
      (DENSITY_KBIT <= 4) ? ABASE_4K :
      ABASE_16K;
   localparam logic [3:0] IGN = ((DENSITY_KBIT == 2) || (DENSITY_KBIT == 8)) ?
      4'h1 : 4'h0;

   // Whole decoder state
   typedef struct packed {
      eed_state_t st;
      logic sel_prev;
      logic sclk_prev;
      logic [4:0] cnt;
      logic [4:0] bitn;
      logic [1:0] opc;
      logic [ADDR_MAX_W-1:0] addr;
      logic [DATA_MAX_W-1:0] data;
      logic [DATA_MAX_W-1:0] sh;
      logic wen;
      logic status;
      logic dout;
      logic oe;
      logic rd_req;
      logic push;
      logic [CMD_W-1:0] word;
   } eed_core_t;
   eed_core_t c_q;
   eed_core_t c_d;

   logic [3:0] pins_s;
   logic sel_s;
   logic sclk_s;
   logic din_s;
   logic org_s;
   logic buf_ready;
   logic busy;
   logic rise;
   logic [3:0] aw;
   logic [4:0] dw;
   logic [ADDR_MAX_W-1:0] amask;
   logic [ADDR_MAX_W-1:0] addr_n;
   logic [DATA_MAX_W-1:0] data_n;
   logic [1:0] sub;
   logic has_data;
   logic [4:0] expect_cnt;

   // Pins come from the master's domain
   eed_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .async_in({sel_in, sclk_in, din_in, org_in}),
      .sync_out(pins_s)
   );
   assign {sel_s, sclk_s, din_s, org_s} = pins_s;

   // Field geometry from width pin and density
   always_comb
   begin
      aw = ABASE + (org_s ? 4'h0 : 4'h1);
      dw = org_s ? WORD_W : BYTE_W;
      amask = ADDR_MAX_W'((12'h001 << (aw - IGN)) - 12'h001);
      addr_n = ADDR_MAX_W'({c_q.addr, din_s});
      data_n = {c_q.data[DATA_MAX_W-2:0], din_s};
      // Only the two leading bits matter; the rest are don't-care
      sub = 2'(c_q.addr >> (aw - 4'h2));
      has_data = (c_q.opc == OPC_WRITE) ||
         ((c_q.opc == OPC_SPECIAL) && (sub == FILL_ALL_SUB));
      // Start + op-code + address (+ data)
      expect_cnt = HDR_CLKS + 5'(aw) + (has_data ? dw : 5'h00);
   end

   // Self-timed cycle or a queued command makes the device busy
   assign busy = array_busy_in || cmd_valid_out || !buf_ready;
   // Edges found by sampling; no edge is expected at any given rate
   assign rise = sclk_s && !c_q.sclk_prev;

   // Decoder next state
   always_comb
   begin
      c_d = c_q;
      c_d.sel_prev = sel_s;
      c_d.sclk_prev = sclk_s;
      c_d.push = 1'b0;
      // Array answer loads the output shifter
      if (rd_ack_in && c_q.rd_req)
      begin
         c_d.rd_req = 1'b0;
         c_d.sh = org_s ? rd_data_in : {rd_data_in[7:0], 8'h00};
      end
      if (!sel_s && c_q.sel_prev)
      begin
         // Select fell: act only on a full instruction
         if (c_q.st == st_tail)
         begin
            case (c_q.opc)
               OPC_WRITE:
               begin
                  // Exact count and writes enabled, else abort
                  if (c_q.wen && (c_q.cnt == expect_cnt))
                  begin
                     c_d.push = 1'b1;
                     c_d.word = {write_one_cmd, c_q.addr & amask, c_q.data};
                  end
               end
               OPC_ERASE:
               begin
                  if (c_q.wen && (c_q.cnt == expect_cnt))
                  begin
                     c_d.push = 1'b1;
                     c_d.word = {erase_one_cmd, c_q.addr & amask, 16'h0000};
                  end
               end
               OPC_SPECIAL:
               begin
                  case (sub)
                     ENABLE_WRITES_CMD: c_d.wen = 1'b1;
                     DISABLE_WRITES_CMD: c_d.wen = 1'b0;
                     ERASE_ALL_SUB:
                     begin
                        if (c_q.wen && (c_q.cnt == expect_cnt))
                        begin
                           c_d.push = 1'b1;
                           c_d.word = {erase_everything_cmd, 11'h000, 16'h0000};
                        end
                     end
                     default:
                     begin
                        if (c_q.wen && (c_q.cnt == expect_cnt))
                        begin
                           c_d.push = 1'b1;
                           c_d.word = {fill_everything_cmd, 11'h000, c_q.data};
                        end
                     end
                  endcase
               end
               default:
               begin
                  c_d.push = 1'b0;
               end
            endcase
            // Show busy/ready on the next select high
            if (c_d.push)
            begin
               c_d.status = 1'b1;
            end
         end
         // Partial instructions just vanish
         c_d.st = st_idle;
         c_d.oe = 1'b0;
         c_d.dout = DOUT_RST;
         c_d.rd_req = 1'b0;
      end
      else if (sel_s)
      begin
         case (c_q.st)
            st_idle:
            begin
               // Select rose: hunt, or report status
               c_d.st = c_q.status ? st_status : st_hunt;
               c_d.oe = c_q.status;
               c_d.dout = !busy;
            end
            st_status:
            begin
               c_d.dout = !busy;
               // Start bit only once ready; input ignored while busy
               if (rise && din_s && !busy)
               begin
                  c_d.status = 1'b0;
                  c_d.oe = 1'b0;
                  c_d.dout = DOUT_RST;
                  c_d.st = st_opc;
                  c_d.cnt = 5'h01;
                  c_d.bitn = 5'h00;
               end
            end
            st_hunt:
            begin
               // Leading zeros are skipped
               if (rise && din_s && !busy)
               begin
                  c_d.st = st_opc;
                  c_d.cnt = 5'h01;
                  c_d.bitn = 5'h00;
               end
            end
            st_opc:
            begin
               if (rise)
               begin
                  c_d.opc = {c_q.opc[0], din_s};
                  c_d.cnt = c_q.cnt + 5'h01;
                  c_d.bitn = c_q.bitn + 5'h01;
                  if (c_q.bitn == 5'h01)
                  begin
                     c_d.st = st_addr;
                     c_d.bitn = 5'h00;
                     c_d.addr = '0;
                  end
               end
            end
            st_addr:
            begin
               if (rise)
               begin
                  c_d.addr = addr_n;
                  c_d.cnt = c_q.cnt + 5'h01;
                  c_d.bitn = c_q.bitn + 5'h01;
                  if (c_q.bitn == 5'(aw - 4'h1))
                  begin
                     c_d.bitn = 5'h00;
                     if (c_q.opc == OPC_READ)
                     begin
                        // Dummy zero first, fetch the location
                        c_d.st = st_read;
                        c_d.addr = addr_n & amask;
                        c_d.dout = 1'b0;
                        c_d.oe = 1'b1;
                        c_d.rd_req = 1'b1;
                     end
                     else if ((c_q.opc == OPC_WRITE) || ((c_q.opc == OPC_SPECIAL) &&
                        (2'(addr_n >> (aw - 4'h2)) == FILL_ALL_SUB)))
                     begin
                        c_d.st = st_data;
                     end
                     else
                     begin
                        c_d.st = st_tail;
                     end
                  end
               end
            end
            st_data:
            begin
               if (rise)
               begin
                  c_d.data = data_n;
                  c_d.cnt = c_q.cnt + 5'h01;
                  c_d.bitn = c_q.bitn + 5'h01;
                  if (c_q.bitn == (dw - 5'h01))
                  begin
                     // Byte sits in the low bits
                     c_d.data = org_s ? data_n : {8'h00, data_n[7:0]};
                     c_d.st = st_tail;
                  end
               end
            end
            st_tail:
            begin
               // Extra clocks spoil the count
               if (rise && (c_q.cnt != CNT_MAX))
               begin
                  c_d.cnt = c_q.cnt + 5'h01;
               end
            end
            st_read:
            begin
               if (rise)
               begin
                  c_d.dout = c_q.sh[DATA_MAX_W-1];
                  c_d.sh = {c_q.sh[DATA_MAX_W-2:0], 1'b0};
                  c_d.bitn = c_q.bitn + 5'h01;
                  if (c_q.bitn == (dw - 5'h01))
                  begin
                     // Next location, rolls over, no dummy bit
                     c_d.bitn = 5'h00;
                     c_d.addr = (c_q.addr + 11'h001) & amask;
                     c_d.rd_req = 1'b1;
                  end
               end
            end
            default:
            begin
               c_d.st = st_idle;
            end
         endcase
      end
   end

   // Register the decoder; writes start disabled
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         c_q <= '0;
         c_q.st <= st_idle;
         c_q.wen <= WEN_RST;
      end
      else
      begin
         c_q <= c_d;
      end
   end

   // Commands wait here; a full buffer reads as busy
   eed_buf2 #(
      .WIDTH(CMD_W)
   ) u_buf (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(c_q.push),
      .in_data_in(c_q.word),
      .in_ready_out(buf_ready),
      .out_valid_out(cmd_valid_out),
      .out_data_out({cmd_kind_out, cmd_addr_out, cmd_data_out}),
      .out_ready_in(cmd_ready_in)
   );

   assign dout_out = c_q.dout;
   assign dout_oe_out = c_q.oe;
   assign wen_out = c_q.wen;
   assign rd_req_out = c_q.rd_req;
   assign rd_addr_out = c_q.addr;
endmodule
`default_nettype wire

// [eed_decoder_sva.sv]
/* Port checker for the serial instruction decoder.
   Assumes it is bound into each decoder instance and sees only its ports. */
`default_nettype none
module eed_decoder_sva
   import eed_pkg::*;
#(
   parameter int DENSITY_KBIT = 16
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic sel_in,
   input wire logic sclk_in,
   input wire logic din_in,
   input wire logic org_in,
   input wire logic dout_out,
   input wire logic dout_oe_out,
   input wire logic wen_out,
   input wire logic rd_req_out,
   input wire logic [ADDR_MAX_W-1:0] rd_addr_out,
   input wire logic rd_ack_in,
   input wire logic [DATA_MAX_W-1:0] rd_data_in,
   input wire logic array_busy_in,
   input wire logic cmd_valid_out,
   input wire logic [1:0] cmd_kind_out,
   input wire logic [ADDR_MAX_W-1:0] cmd_addr_out,
   input wire logic [DATA_MAX_W-1:0] cmd_data_out,
   input wire logic cmd_ready_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Decoded address bits per density; anything above must stay zero
   localparam int ABITS = DENSITY_KBIT == 1 ? 7 : DENSITY_KBIT == 2 ? 8 :
      DENSITY_KBIT == 4 ? 9 : DENSITY_KBIT == 8 ? 10 : 11;
   // One clock domain only
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   reset_idle_a: assert property ($rose(rst_n_in) |-> !wen_out && !cmd_valid_out && !dout_oe_out)
      else $error("outputs not idle after reset");
   cmd_hold_a: assert property (cmd_valid_out && !cmd_ready_in |=> cmd_valid_out &&
      $stable(cmd_kind_out) && $stable(cmd_addr_out) && $stable(cmd_data_out))
      else $error("stalled command changed");
   rd_hold_a: assert property (rd_req_out && !rd_ack_in |=> rd_req_out && $stable(rd_addr_out))
      else $error("read request dropped early");
   rd_done_a: assert property (rd_ack_in && rd_req_out |=> !rd_req_out)
      else $error("read request outlived its answer");
   oe_release_a: assert property (!sel_in [*6] |-> !dout_oe_out)
      else $error("output driven while deselected");
   dummy_bit_a: assert property ($rose(dout_oe_out) && rd_req_out |-> !dout_out)
      else $error("read stream lacks leading zero");
   busy_low_a: assert property (dout_oe_out && array_busy_in && $past(array_busy_in) &&
      $past(array_busy_in, 2) |-> !dout_out)
      else $error("busy not shown as zero");
   addr_top_a: assert property (cmd_valid_out |-> (cmd_addr_out >> ABITS) == '0)
      else $error("undecoded address bit passed on");
   all_addr_a: assert property (cmd_valid_out && cmd_kind_out[1] |-> cmd_addr_out == '0)
      else $error("whole-array command has an address");
   erase_data_a: assert property (cmd_valid_out && ^cmd_kind_out |-> cmd_data_out == '0)
      else $error("erase carries data");
   wen_gate_a: assert property ($rose(cmd_valid_out) |-> wen_out)
      else $error("command issued with writes disabled");
endmodule
bind eed_decoder eed_decoder_sva #(.DENSITY_KBIT(DENSITY_KBIT)) u_sva (.clk_in, .rst_n_in,
   .sel_in, .sclk_in, .din_in, .org_in, .dout_out, .dout_oe_out, .wen_out, .rd_req_out,
   .rd_addr_out, .rd_ack_in, .rd_data_in, .array_busy_in, .cmd_valid_out, .cmd_kind_out,
   .cmd_addr_out, .cmd_data_out, .cmd_ready_in);
`default_nettype wire

// [eed_master.sv]
/* Serial bus master model: frames instructions on select, clock and data.
   Assumes a 20 ns clk_in; the serial clock runs at 160 ns inside frames only. */
`default_nettype none
module eed_master
(
   input wire logic clk_in,
   input wire logic dout_in,
   output logic sel_out,
   output logic sclk_out,
   output logic din_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] rx; // Output bits seen, newest in bit 0
   // Deselected and clock parked low from time zero
   initial
   begin
      sel_out = 1'b0;
      sclk_out = 1'b0;
      din_out = 1'b0;
      rx = '0;
   end
   // Half a serial period
   task automatic half();
      repeat (4) @(negedge clk_in);
   endtask
   // Sends n bits MSB first, sampling dout before each rise and at the end
   task automatic xfer(input logic [31:0] b, input int n);
      sel_out = 1'b1; // Clock still low at select rise
      half();
      for (int i = n - 1; i >= 0; i--)
      begin
         din_out = b[i];
         half();
         rx = {rx[30:0], dout_in};
         sclk_out = 1'b1;
         half();
         sclk_out = 1'b0;
      end
      half();
      rx = {rx[30:0], dout_in};
      sel_out = 1'b0;
      din_out = ~din_out; // Released line never shows its last value
      half();
      half();
   endtask
endmodule
`default_nettype wire

// [eed_decoder_tb_top.sv]
/* Testbench for the instruction decoder at 2-Kbit, plus an 8-Kbit twin on the same pins.
   Assumes the master model and the bound checker; the bench plays the array. */
`default_nettype none
module eed_decoder_tb_top;
   import eed_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0; // 50 MHz
   logic rst_n_in = 1'b0; // Low for eight cycles
   logic org = 1'b0; // Byte organisation first
   logic rd_ack = 1'b0; // Array read answer
   logic busy = 1'b0; // Array self-timed cycle
   logic cmd_rdy = 1'b0; // Array stalls until a check is done
   logic sel, sclk, din, dout, oe, wen, rd_req, cmd_valid;
   logic [1:0] kind;
   logic [10:0] rd_addr, cmd_addr;
   logic [15:0] rd_data, cmd_data;
   logic v8, r8, rdy8 = 1'b0; // 8-Kbit twin: command valid, read loop, array ready
   logic [1:0] k8;
   logic [10:0] a8;
   logic [15:0] d8;
   int error_cnt = 0;
   int total_checks = 0;
   always #10 clk_in = ~clk_in;
   // Content is a pattern of the address, so a wrong address shows up
   assign rd_data = 16'h5A3C ^ {5'h00, rd_addr};
   // Answer each read one cycle later, never next to a serial rise
   always @(negedge clk_in) rd_ack <= rd_req && !rd_ack;
   eed_decoder #(.DENSITY_KBIT(2)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sel_in(sel),
      .sclk_in(sclk), .din_in(din), .org_in(org), .dout_out(dout), .dout_oe_out(oe),
      .wen_out(wen), .rd_req_out(rd_req), .rd_addr_out(rd_addr), .rd_ack_in(rd_ack),
      .rd_data_in(rd_data), .array_busy_in(busy), .cmd_valid_out(cmd_valid),
      .cmd_kind_out(kind), .cmd_addr_out(cmd_addr), .cmd_data_out(cmd_data),
      .cmd_ready_in(cmd_rdy));
   eed_master m (.clk_in(clk_in), .dout_in(dout), .sel_out(sel), .sclk_out(sclk),
      .din_out(din));
   // Twin answers its own reads at once, so a pending request never meets a select fall
   eed_decoder #(.DENSITY_KBIT(8)) dut8 (.clk_in(clk_in), .rst_n_in(rst_n_in), .sel_in(sel),
      .sclk_in(sclk), .din_in(din), .org_in(org), .dout_out(), .dout_oe_out(), .wen_out(),
      .rd_req_out(r8), .rd_addr_out(), .rd_ack_in(r8), .rd_data_in(rd_data),
      .array_busy_in(busy), .cmd_valid_out(v8), .cmd_kind_out(k8), .cmd_addr_out(a8),
      .cmd_data_out(d8), .cmd_ready_in(rdy8));
   task automatic chk_bit(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_word(input string what, input logic [16:0] exp, input logic [16:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Waits for a queued command, judges it, then lets the array take it
   task automatic take_cmd(input logic [1:0] k, input logic [10:0] a, input logic [15:0] d);
      int n;
      n = 0;
      while (cmd_valid !== 1'b1 && n < 40)
      begin
         @(negedge clk_in);
         n++;
      end
      chk_bit("cmd_valid", 1'b1, cmd_valid);
      chk_word("cmd_kind", {15'h0000, k}, {15'h0000, kind});
      chk_word("cmd_addr", {6'h00, a}, {6'h00, cmd_addr});
      chk_word("cmd_data", {1'b0, d}, {1'b0, cmd_data});
      cmd_rdy = 1'b1;
      @(negedge clk_in);
      cmd_rdy = 1'b0;
   endtask
   // No command may appear
   task automatic no_cmd();
      repeat (20) @(negedge clk_in);
      chk_bit("cmd_valid", 1'b0, cmd_valid);
   endtask
   // Refused write while locked, then enable with junk in the free bits
   task automatic t_enable();
      chk_bit("wen", 1'b0, wen);
      m.xfer({12'h000, 3'b101, 9'h1A5, 8'hC3}, 20);
      no_cmd();
      m.xfer({20'h00000, 3'b100, 9'h1AD}, 12);
      chk_bit("wen", 1'b1, wen);
   endtask
   // Write after leading zeros; status while the command waits
   task automatic t_write();
      m.xfer({10'h000, 3'b001, 2'b01, 9'h1A5, 8'hC3}, 22);
      m.xfer(32'h00000000, 0);
      chk_bit("status", 1'b0, m.rx[0]);
      take_cmd(2'h0, 11'h0A5, 16'h00C3);
   endtask
   // One clock too many, one too few
   task automatic t_count();
      m.xfer({11'h000, 3'b101, 9'h0F0, 8'h55, 1'b0}, 21);
      no_cmd();
      m.xfer({21'h000000, 3'b111, 8'h12}, 11);
      no_cmd();
   endtask
   // Erase, erase everything, fill everything in byte mode
   task automatic t_kinds();
      m.xfer({20'h00000, 3'b111, 9'h133}, 12);
      take_cmd(2'h1, 11'h033, 16'h0000);
      m.xfer({20'h00000, 3'b100, 9'h12A}, 12);
      take_cmd(2'h2, 11'h000, 16'h0000);
      m.xfer({12'h000, 3'b100, 9'h0B1, 8'h96}, 20);
      take_cmd(2'h3, 11'h000, 16'h0096);
   endtask
   // Word mode fill and write, top address bit ignored
   task automatic t_word();
      org = 1'b1;
      m.xfer({5'h00, 3'b100, 8'h6A, 16'hBEEF}, 27);
      take_cmd(2'h3, 11'h000, 16'hBEEF);
      m.xfer({5'h00, 3'b101, 8'hA7, 16'h1234}, 27);
      take_cmd(2'h0, 11'h027, 16'h1234);
      org = 1'b0;
   endtask
   // Read two bytes across the wrap of the decoded range
   task automatic t_read();
      m.xfer({4'h0, 3'b110, 9'h0FF, 16'h0000}, 28);
      chk_word("read stream", {1'b0, 8'hC3, 8'h3C}, m.rx[16:0]);
   endtask
   // Partial frame dropped, next instruction still decoded
   task automatic t_drop();
      m.xfer({24'h000000, 3'b101, 5'h15}, 8);
      no_cmd();
      m.xfer({20'h00000, 3'b111, 9'h001}, 12);
      take_cmd(2'h1, 11'h001, 16'h0000);
   endtask
   // Array busy: status low, start bits ignored
   task automatic t_busy();
      busy = 1'b1;
      m.xfer(32'h00000000, 0);
      chk_bit("busy status", 1'b0, m.rx[0]);
      m.xfer({20'h00000, 3'b111, 9'h002}, 12);
      no_cmd();
      busy = 1'b0;
      m.xfer(32'h00000000, 0);
      chk_bit("ready status", 1'b1, m.rx[0]);
   endtask
   // Disable, then an erase must be refused
   task automatic t_disable();
      m.xfer({20'h00000, 3'b100, 9'h05A}, 12);
      chk_bit("wen", 1'b0, wen);
      m.xfer({20'h00000, 3'b111, 9'h003}, 12);
      no_cmd();
   endtask
   // 8-Kbit frames: the twin enables and writes, the 2-Kbit part sees a bad count
   task automatic t_dense();
      m.xfer({18'h00000, 3'b100, 11'h600}, 14);
      m.xfer({10'h000, 3'b101, 11'h5A5, 8'h3C}, 22);
      chk_bit("cmd_valid 8k", 1'b1, v8);
      chk_word("cmd_kind 8k", {15'h0000, 2'h0}, {15'h0000, k8});
      chk_word("cmd_addr 8k", {6'h00, 11'h1A5}, {6'h00, a8});
      chk_word("cmd_data 8k", {9'h000, 8'h3C}, {1'b0, d8});
      rdy8 = 1'b1;
      no_cmd();
      rdy8 = 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (8) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (6) @(negedge clk_in);
      t_enable();
      t_write();
      t_count();
      t_kinds();
      t_word();
      t_read();
      t_drop();
      t_busy();
      t_disable();
      t_dense();
      report_and_stop();
   end
   // Watchdog, well beyond the expected run of about 60 us
   initial
   begin
      #400000;
      error_cnt++;
      $display("mismatch watchdog expected done seen hang");
      report_and_stop();
   end
endmodule
`default_nettype wire
